// file: rtl/dfte_pkg.sv
package dfte_pkg;
	localparam int unsigned CLK_PERIOD_NS = 20;
	localparam int unsigned NS_PER_US = 1000;
	localparam int unsigned US_CYC = NS_PER_US / CLK_PERIOD_NS;
	localparam int unsigned GUARD_US = 4;
	localparam int unsigned REF_US = 8;
	localparam int unsigned UNIT_US = 8;
	localparam logic [5:0] MIN_UNITS = 6'h02;
	localparam logic [5:0] CAP_STD = 6'h14;
	localparam logic [5:0] CAP_5B = 6'h1F;
	localparam logic [5:0] CAP_6B = 6'h3F;
	localparam logic [15:0] UNIT_CYC = 16'(UNIT_US * US_CYC);
	localparam logic [15:0] GREF_CYC = 16'((GUARD_US + REF_US) * US_CYC);
	localparam logic [15:0] REF_CYC = 16'(REF_US * US_CYC);
	localparam logic [15:0] US16 = 16'(US_CYC);
	localparam logic [7:0] SP4_CYC = 8'(4 * US_CYC);
	localparam logic [7:0] SP2_CYC = 8'(2 * US_CYC);
	localparam logic [7:0] SP1_CYC = 8'(US_CYC);
	localparam logic [7:0] SPH_CYC = 8'(US_CYC / 2);
	localparam logic [2:0] SP_4US = 3'h1;
	localparam logic [2:0] SP_2US = 3'h2;
	localparam logic [2:0] SP_1US = 3'h3;
	localparam logic [2:0] SP_HALF = 3'h4;
	localparam logic [1:0] TT_SHORT = 2'h1;
	localparam logic [1:0] TT_LONG = 2'h2;
	localparam logic [11:0] OFS_CTRL = 12'h000;
	localparam logic [11:0] OFS_OFFSET = 12'h004;
	localparam logic [11:0] OFS_INLINE = 12'h008;
	localparam logic [11:0] OFS_PATTERN = 12'h00C;
	localparam logic [11:0] OFS_TASK = 12'h010;
	localparam logic [11:0] OFS_PTR = 12'h014;
	localparam logic [11:0] OFS_MAX = 12'h018;
	localparam logic [11:0] OFS_AMOUNT = 12'h01C;
	localparam logic [11:0] OFS_STATUS = 12'h020;
	localparam logic [11:0] OFS_PIN0 = 12'h040;
	localparam int C_MODE = 0;
	localparam int C_TRANSMIT_ENABLE_TASK = 1;
	localparam int C_TRIG = 2;
	localparam int C_FMT = 3;
	localparam int C_SWSP = 8;
	localparam int C_REFSP = 12;
	localparam int C_POSTSP = 16;
	localparam int C_LEN = 24;
	localparam int I_EN = 0;
	localparam int I_DATA = 1;
	localparam int I_RANGE = 2;
	localparam int I_SHORT = 4;
	localparam int I_LONG = 8;
	localparam int I_MASK = 16;
	localparam int I_MATCH = 24;
	localparam int PIN_CONN = 5;
	localparam int PRESENT_BIT = 5;
	localparam int FLAG_CTE = 2;
	localparam logic [5:0] ADV_SKIP = 6'h06;
	localparam logic [5:0] ADV_INFO0 = 6'h04;
	localparam logic [5:0] DC_INFO = 6'h02;
	localparam int NSIG = 8;
	localparam int NPIN = 32;
	localparam int DEPTH = 16;
	localparam logic [4:0] DEPTH5 = 5'h10;
	localparam logic [3:0] IDX_LOOP = 4'h2;
	localparam logic signed [8:0] PH_MAX = 9'sh0C9;
	localparam logic [15:0] SAT_NEG = 16'h8000;
	typedef enum logic [4:0] {
		SW_IDLE = 5'h01,
		SW_OFS = 5'h02,
		SW_REF = 5'h04,
		SW_SLOT = 5'h08,
		SW_TAIL = 5'h10
	} dfte_sw_t;
endpackage : dfte_pkg

// file: rtl/dfte_engine.sv
// The placing of the registers and the APB register port were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
module dfte_engine
	import dfte_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire logic [11:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic transmit_enable_task,
	input wire logic receive_enable_task,
	input wire logic address_event,
	input wire logic crc_end,
	input wire logic rx_byte_valid,
	input wire logic [7:0] rx_byte,
	input wire logic [11:0] iq_i,
	input wire logic [11:0] iq_q,
	input wire logic iq_i_ovf,
	input wire logic iq_q_ovf,
	input wire logic [12:0] mag_in,
	input wire logic [8:0] phase_in,
	output logic tone_tx,
	output logic tone_found_event,
	output logic [NPIN-1:0] pin_out,
	output logic [NPIN-1:0] pin_oe,
	output logic dma_req,
	output logic [31:0] dma_addr,
	output logic [31:0] dma_wdata,
	input wire logic dma_ack
);
	logic [31:0] ctrl_q, inl_q, ptr_q;
	logic [15:0] ofs_q, max_q, amount_q;
	logic [5:0] pin_q [NSIG];
	logic [7:0] pat_q [DEPTH];
	logic [4:0] pat_n_q;
	logic [3:0] wr_idx_q, sw_idx_q;
	logic [31:0] rdata_d;
	logic err_d, wr;
	logic dir_tx_q, acq_q, run_q, smp_on_q, ref_go_q;
	logic [15:0] el_q, sw_cnt_q, smp_cnt_q, ref_left_q;
	logic [7:0] cur_q, b0_q, info_q;
	logic [5:0] bidx_q, info_idx_q;
	logic want_q, found_q, rel_q;
	dfte_sw_t sw_q;

	function automatic logic [7:0] sp_cyc(input logic [2:0] c);
		unique case (c)
			SP_4US: sp_cyc = SP4_CYC;
			SP_2US: sp_cyc = SP2_CYC;
			SP_HALF: sp_cyc = SPH_CYC;
			default: sp_cyc = SP1_CYC;
		endcase
	endfunction : sp_cyc

	// apb: one wait state, pready from flop
	assign wr = psel && penable && pwrite && pready;
	always_comb begin
		rdata_d = '0;
		err_d = 1'b0;
		if (paddr[11:5] == OFS_PIN0[11:5]) begin
			rdata_d = {26'h0, pin_q[paddr[4:2]]};
		end else begin
			unique case (paddr)
				OFS_CTRL: rdata_d = ctrl_q;
				OFS_OFFSET: rdata_d = {16'h0, ofs_q};
				OFS_INLINE: rdata_d = inl_q;
				OFS_PATTERN: rdata_d = {27'h0, pat_n_q};
				OFS_TASK: rdata_d = '0;
				OFS_PTR: rdata_d = ptr_q;
				OFS_MAX: rdata_d = {16'h0, max_q};
				OFS_AMOUNT: rdata_d = {16'h0, amount_q};
				OFS_STATUS: rdata_d = {found_q, 11'h0, run_q, acq_q,
					smp_on_q, dir_tx_q, cur_q, info_q};
				default: err_d = 1'b1;
			endcase
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			pready <= 1'b0;
			prdata <= '0;
			pslverr <= 1'b0;
		end else begin
			pready <= psel && penable && !pready;
			pslverr <= psel && penable && !pready && err_d;
			if (psel && penable && !pready) begin
				prdata <= pwrite ? 32'h0 : rdata_d;
			end
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ctrl_q <= '0;
			ofs_q <= '0;
			inl_q <= '0;
			ptr_q <= '0;
			max_q <= '0;
			for (int n = 0; n < NSIG; n++) pin_q[n] <= '0;
		end else if (wr && !err_d) begin
			if (paddr[11:5] == OFS_PIN0[11:5]) begin
				pin_q[paddr[4:2]] <= pwdata[5:0];
			end
			if (paddr == OFS_CTRL) ctrl_q <= pwdata;
			if (paddr == OFS_OFFSET) ofs_q <= pwdata[15:0];
			if (paddr == OFS_INLINE) inl_q <= pwdata;
			if (paddr == OFS_PTR) ptr_q <= pwdata;
			if (paddr == OFS_MAX) max_q <= pwdata[15:0];
		end
	end

	// pattern buffer fill, overwrite wraps to entry 2
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			pat_n_q <= '0;
			wr_idx_q <= '0;
			for (int e = 0; e < DEPTH; e++) pat_q[e] <= '0;
		end else if (wr && paddr == OFS_TASK && pwdata[0]) begin
			pat_n_q <= '0;
			wr_idx_q <= '0;
		end else if (wr && paddr == OFS_PATTERN) begin
			pat_q[wr_idx_q] <= pwdata[7:0];
			if (pat_n_q != DEPTH5) pat_n_q <= pat_n_q + 5'h1;
			wr_idx_q <= (wr_idx_q == 4'(DEPTH - 1)) ? IDX_LOOP :
				wr_idx_q + 4'h1;
		end
	end

	logic inline_rx, aod, sw_en, go_ok, run_go, trig, proc_go, done;
	logic hdr_ok;
	logic [5:0] t_raw, cap, units;
	logic [15:0] len_cyc;
	logic [2:0] post_code;
	logic [7:0] sw_sp, ref_sp, post_sp;
	assign aod = ctrl_q[C_MODE];
	assign inline_rx = inl_q[I_EN] && !dir_tx_q;
	assign sw_en = aod ? dir_tx_q : !dir_tx_q;
	assign hdr_ok = (rx_byte & inl_q[I_MASK +: 8]) == inl_q[I_MATCH +: 8];
	always_comb begin
		unique case (inl_q[I_RANGE +: 2])
			2'h0: cap = CAP_STD;
			2'h1: cap = CAP_5B;
			default: cap = CAP_6B;
		endcase
		t_raw = inl_q[I_RANGE + 1] ? info_q[5:0] : {1'b0, info_q[4:0]};
		if (!inline_rx) t_raw = {1'b0, ctrl_q[C_LEN +: 5]};
		units = (t_raw < MIN_UNITS) ? MIN_UNITS :
			(t_raw > cap && inline_rx) ? cap : t_raw;
		post_code = ctrl_q[C_POSTSP +: 3];
		if (inline_rx) begin
			if (aod) begin
				if (info_q[7:6] == TT_SHORT)
					post_code = inl_q[I_SHORT +: 3];
				else if (info_q[7:6] == TT_LONG)
					post_code = inl_q[I_LONG +: 3];
			end else if (ctrl_q[C_SWSP +: 3] == SP_2US) begin
				post_code = inl_q[I_SHORT +: 3];
			end else if (ctrl_q[C_SWSP +: 3] == SP_4US) begin
				post_code = inl_q[I_LONG +: 3];
			end
		end
	end
	assign len_cyc = 16'({10'h0, units} * UNIT_CYC);
	assign sw_sp = sp_cyc(ctrl_q[C_SWSP +: 3]);
	assign ref_sp = sp_cyc(ctrl_q[C_REFSP +: 3]);
	assign post_sp = sp_cyc(post_code);
	assign go_ok = dir_tx_q ? ctrl_q[C_TRANSMIT_ENABLE_TASK] : (!inl_q[I_EN] || found_q);
	assign run_go = crc_end && go_ok;
	assign trig = (!inline_rx && ctrl_q[C_TRIG]) ? address_event :
		crc_end;
	assign proc_go = trig && go_ok;
	assign done = run_q && el_q == len_cyc - 16'h1;

	// inline parse of header octets
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			bidx_q <= '0;
			b0_q <= '0;
			info_q <= '0;
			info_idx_q <= '0;
			want_q <= 1'b0;
			found_q <= 1'b0;
			tone_found_event <= 1'b0;
		end else begin
			tone_found_event <= 1'b0;
			if (address_event) begin
				bidx_q <= '0;
				want_q <= 1'b0;
				found_q <= 1'b0;
			end else if (rx_byte_valid && inline_rx) begin
				if (bidx_q != 6'h3F) bidx_q <= bidx_q + 6'h1;
				if (bidx_q == 6'h0) begin
					b0_q <= rx_byte;
					want_q <= hdr_ok && (!inl_q[I_DATA] ||
						rx_byte[PRESENT_BIT]);
					info_idx_q <= inl_q[I_DATA] ? DC_INFO : ADV_INFO0;
				end else if (want_q && bidx_q == info_idx_q) begin
					info_q <= rx_byte;
					found_q <= 1'b1;
					want_q <= 1'b0;
					tone_found_event <= 1'b1;
				end else if (!inl_q[I_DATA] && bidx_q == 6'h2) begin
					if (rx_byte[5:0] == 6'h0) want_q <= 1'b0;
				end else if (!inl_q[I_DATA] && bidx_q == 6'h3) begin
					want_q <= want_q && rx_byte[FLAG_CTE];
					info_idx_q <= ADV_INFO0 +
						(rx_byte[0] ? ADV_SKIP : 6'h0) +
						(rx_byte[1] ? ADV_SKIP : 6'h0);
				end
			end
		end
	end

	// tone window and transmitted ones
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			dir_tx_q <= 1'b0;
			run_q <= 1'b0;
			el_q <= '0;
			tone_tx <= 1'b0;
		end else begin
			if (transmit_enable_task) dir_tx_q <= 1'b1;
			if (receive_enable_task) dir_tx_q <= 1'b0;
			if (run_go) begin
				run_q <= 1'b1;
				el_q <= '0;
			end else if (done) begin
				run_q <= 1'b0;
			end else if (run_q) begin
				el_q <= el_q + 16'h1;
			end
			tone_tx <= dir_tx_q && (run_go || (run_q && !done));
		end
	end

	// antenna switcher
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			sw_q <= SW_IDLE;
			sw_cnt_q <= '0;
			sw_idx_q <= IDX_LOOP;
			cur_q <= '0;
			acq_q <= 1'b0;
			rel_q <= 1'b0;
		end else begin
			if (transmit_enable_task || receive_enable_task) begin
				cur_q <= pat_q[0];
				acq_q <= aod ? transmit_enable_task : receive_enable_task;
				rel_q <= 1'b0;
				sw_q <= SW_IDLE;
			end else begin
				// entry 0 stands on the pins one cycle before release
				rel_q <= 1'b0;
				if (rel_q) acq_q <= 1'b0;
				unique case (sw_q)
					SW_IDLE: if (proc_go && sw_en) begin
						sw_q <= SW_OFS;
						sw_cnt_q <= 16'(ofs_q[7:0] * US16);
					end
					SW_OFS: if (sw_cnt_q == 16'h0) begin
						cur_q <= pat_q[1];
						sw_idx_q <= IDX_LOOP;
						sw_cnt_q <= GREF_CYC - 16'h1;
						sw_q <= SW_REF;
					end else begin
						sw_cnt_q <= sw_cnt_q - 16'h1;
					end
					SW_REF, SW_SLOT: if (done) begin
						// tail runs on from the last switch, cut to one slot after tone end if longer
						if (sw_cnt_q > {8'h0, sw_sp})
							sw_cnt_q <= {8'h0, sw_sp} - 16'h1;
						else if (sw_cnt_q != 16'h0)
							sw_cnt_q <= sw_cnt_q - 16'h1;
						sw_q <= SW_TAIL;
					end else if (sw_cnt_q == 16'h0) begin
						cur_q <= pat_q[sw_idx_q];
						sw_idx_q <= ({1'b0, sw_idx_q} + 5'h1 >= pat_n_q) ?
							IDX_LOOP : sw_idx_q + 4'h1;
						sw_cnt_q <= {8'h0, sw_sp} - 16'h1;
						sw_q <= SW_SLOT;
					end else begin
						sw_cnt_q <= sw_cnt_q - 16'h1;
					end
					SW_TAIL: if (sw_cnt_q == 16'h0) begin
						cur_q <= pat_q[0];
						rel_q <= 1'b1;
						sw_q <= SW_IDLE;
					end else begin
						sw_cnt_q <= sw_cnt_q - 16'h1;
					end
				endcase
			end
		end
	end

	generate
		for (genvar p = 0; p < NPIN; p++) begin : g_pin
			always_ff @(posedge clk or posedge rst) begin
				if (rst) begin
					pin_out[p] <= 1'b0;
					pin_oe[p] <= 1'b0;
				end else begin
					pin_out[p] <= 1'b0;
					pin_oe[p] <= 1'b0;
					for (int n = 0; n < NSIG; n++) begin
						if (acq_q && pin_q[n][PIN_CONN] &&
							pin_q[n][4:0] == 5'(p)) begin
							pin_out[p] <= cur_q[n];
							pin_oe[p] <= 1'b1;
						end
					end
				end
			end
		end
	endgenerate

	// sampler and dma
	logic take;
	logic [15:0] ival, qval;
	logic signed [8:0] ph;
	assign take = smp_on_q && smp_cnt_q == 16'h0 && !done;
	assign ival = iq_i_ovf ? SAT_NEG : {{4{iq_i[11]}}, iq_i};
	assign qval = iq_q_ovf ? SAT_NEG : {{4{iq_q[11]}}, iq_q};
	assign ph = ($signed(phase_in) > PH_MAX) ? PH_MAX :
		($signed(phase_in) < -PH_MAX) ? -PH_MAX : $signed(phase_in);
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			smp_on_q <= 1'b0;
			smp_cnt_q <= '0;
			ref_left_q <= '0;
			ref_go_q <= 1'b0;
		end else if (proc_go && !dir_tx_q) begin
			smp_on_q <= 1'b1;
			smp_cnt_q <= 16'(ofs_q[15:8] * US16);
			ref_left_q <= REF_CYC;
			ref_go_q <= 1'b0;
		end else if (done) begin
			smp_on_q <= 1'b0;
		end else if (smp_on_q) begin
			if (take) ref_go_q <= 1'b1;
			if (ref_go_q && ref_left_q != 16'h0)
				ref_left_q <= ref_left_q - 16'h1;
			if (take)
				smp_cnt_q <= {8'h0, (ref_left_q > 16'h1) ? ref_sp :
					post_sp} - 16'h1;
			else
				smp_cnt_q <= smp_cnt_q - 16'h1;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			amount_q <= '0;
			dma_req <= 1'b0;
			dma_addr <= '0;
			dma_wdata <= '0;
		end else begin
			if (dma_ack) dma_req <= 1'b0;
			if (proc_go && !dir_tx_q) begin
				amount_q <= '0;
			end else if (take && amount_q < max_q && !dma_req) begin
				dma_req <= 1'b1;
				dma_addr <= ptr_q + {14'h0, amount_q, 2'h0};
				dma_wdata <= ctrl_q[C_FMT] ?
					{3'h0, mag_in, {7{ph[8]}}, ph} :
					{qval, ival};
				amount_q <= amount_q + 16'h1;
			end
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	a_apb_wait: assert property (psel && penable && !pready |=> pready)
		else $error("apb answer late");
	a_apb_pulse: assert property (pready |=> !pready)
		else $error("pready held");
	a_found_cause: assert property (tone_found_event |->
		$past(rx_byte_valid) && found_q)
		else $error("found without octet");
	a_guard_entry: assert property (sw_q == SW_OFS && sw_cnt_q == 16'h0 &&
		!transmit_enable_task && !receive_enable_task |=>
		sw_q == SW_REF && cur_q == pat_q[1])
		else $error("guard entry wrong");
	a_tail_zero: assert property (sw_q == SW_TAIL && sw_cnt_q == 16'h0 &&
		!transmit_enable_task && !receive_enable_task |=>
		cur_q == pat_q[0] && acq_q ##1 !acq_q ##1 pin_oe == '0)
		else $error("tail entry wrong");
	a_idx_loop: assert property (sw_q == SW_SLOT |-> sw_idx_q >= IDX_LOOP)
		else $error("index below loop start");
	a_dma_cap: assert property ($rose(dma_req) |->
		amount_q <= max_q && amount_q != 16'h0)
		else $error("dma past maximum");
	a_iq_sat: assert property ($rose(dma_req) && !ctrl_q[C_FMT] &&
		$past(iq_q_ovf) |-> dma_wdata[31:16] == SAT_NEG)
		else $error("q not saturated");
	a_mag_top: assert property ($rose(dma_req) && ctrl_q[C_FMT] |->
		dma_wdata[31:29] == 3'h0)
		else $error("mag top bits set");
	a_tone_tx: assert property ($rose(tone_tx) |-> $past(crc_end))
		else $error("tone not after crc");
	c_found: cover property (tone_found_event);
	c_tail: cover property (sw_q == SW_TAIL ##1 sw_q == SW_IDLE);
	c_dma: cover property (dma_req && dma_ack);
	c_tone: cover property ($fell(tone_tx));
endmodule : dfte_engine
`default_nettype wire

// file: sim/dfte_ram_model.sv
`timescale 1ns/1ns
`default_nettype none
module dfte_ram_model (
	input wire logic clk,
	input wire logic rst,
	input wire logic [7:0] dly,
	input wire logic dma_req,
	input wire logic [31:0] dma_addr,
	input wire logic [31:0] dma_wdata,
	output logic dma_ack,
	output logic [7:0] cnt_q
);
	logic [31:0] addr_log [16];
	logic [31:0] data_log [16];
	logic [7:0] wait_q;
	// one word taken per request, after dly idle cycles
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			dma_ack <= 1'b0;
			cnt_q <= 8'h00;
			wait_q <= 8'h00;
		end else begin
			dma_ack <= 1'b0;
			if (dma_req && !dma_ack) begin
				if (wait_q >= dly) begin
					dma_ack <= 1'b1;
					addr_log[cnt_q[3:0]] <= dma_addr;
					data_log[cnt_q[3:0]] <= dma_wdata;
					cnt_q <= cnt_q + 8'h01;
					wait_q <= 8'h00;
				end else begin
					wait_q <= wait_q + 8'h01;
				end
			end
		end
	end
endmodule : dfte_ram_model
`default_nettype wire

// file: sim/testbench.sv
`timescale 1ns/1ns
`default_nettype none
module testbench
	import dfte_pkg::*;
;
	logic clk, rst, psel, penable, pwrite, pready, pslverr, err;
	logic [11:0] paddr, iq_i, iq_q;
	logic [31:0] pwdata, prdata, rd, dma_addr, dma_wdata;
	logic [3:0] ev;
	logic rx_byte_valid, iq_i_ovf, iq_q_ovf, tone_tx, tone_found_event;
	logic [7:0] rx_byte, ram_cnt, dly;
	logic [12:0] mag_in;
	logic [8:0] phase_in;
	logic [NPIN-1:0] pin_out, pin_oe;
	logic dma_req, dma_ack;
	int fail_count = 0;
	int n_tests = 0;
	int found_n = 0;
	localparam logic [31:0] CFG [4] = '{32'h3, 32'h3, 32'h0103_0003, 32'h1};
	localparam logic [87:0] PK [4] = '{88'h020820, 88'h020800,
		88'h020822, 88'h02_AAAAAAAAAAAA_05_09_10_00};
	localparam logic EXPF [4] = '{1'b1, 1'b0, 1'b0, 1'b1};

	dfte_engine dut (.clk, .rst, .paddr, .psel, .penable, .pwrite, .pwdata,
		.prdata, .pready, .pslverr, .transmit_enable_task(ev[0]),
		.receive_enable_task(ev[1]), .address_event(ev[2]), .crc_end(ev[3]),
		.rx_byte_valid, .rx_byte, .iq_i, .iq_q, .iq_i_ovf, .iq_q_ovf, .mag_in,
		.phase_in, .tone_tx, .tone_found_event, .pin_out, .pin_oe, .dma_req,
		.dma_addr, .dma_wdata, .dma_ack);
	dfte_ram_model ram (.clk, .rst, .dly, .dma_req, .dma_addr, .dma_wdata,
		.dma_ack, .cnt_q(ram_cnt));

	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	always @(posedge clk) begin
		if (tone_found_event === 1'b1) found_n <= found_n + 1;
	end

	task automatic summarize();
		$display("comparisons %0d mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : summarize
	task automatic chk(input string nm, input logic [31:0] seen, exp);
		n_tests++;
		if (seen !== exp) begin
			fail_count++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk
	task automatic tmo();
		fail_count++;
		$display("CHECK FAILED wait expected done seen timeout");
		summarize();
	endtask : tmo
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int k;
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		paddr <= a;
		pwrite <= w;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		k = 0;
		do begin
			@(posedge clk);
			k++;
		end while (pready !== 1'b1 && k < 20);
		if (pready !== 1'b1) tmo();
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic pulse(input int s);
		@(posedge clk);
		ev[s] <= 1'b1;
		@(posedge clk);
		ev <= 4'h0;
	endtask : pulse
	task automatic wait_cnt(input logic [7:0] t);
		int k;
		for (k = 0; k < 2000 && ram_cnt !== t; k++) @(posedge clk);
		if (ram_cnt !== t) tmo();
	endtask : wait_cnt

	task automatic t_regs();
		int n;
		chk("reset_oe", pin_oe, 32'h0);
		chk("reset_req", 32'(dma_req), 32'h0);
		apb(1'b0, 12'h100, 32'h0);
		chk("unmapped_err", 32'(err), 32'h1);
		chk("unmapped_rd", rd, 32'h0);
		apb(1'b1, OFS_AMOUNT, 32'h5);
		apb(1'b0, OFS_AMOUNT, 32'h0);
		chk("amount_ro", rd, 32'h0);
		for (n = 0; n < 3; n++) apb(1'b1, OFS_PATTERN, 32'(n));
		apb(1'b0, OFS_PATTERN, 32'h0);
		chk("pat_count", rd, 32'h3);
		apb(1'b1, OFS_TASK, 32'h1);
		apb(1'b0, OFS_PATTERN, 32'h0);
		chk("pat_cleared", rd, 32'h0);
		$display("test regs done");
	endtask : t_regs

	task automatic t_tx_plain();
		int k;
		apb(1'b1, OFS_CTRL, 32'h0000_0002);
		pulse(0);
		repeat (2) @(posedge clk);
		chk("oe_aoa_tx", pin_oe, 32'h0);
		pulse(3);
		for (k = 0; k < 10 && tone_tx !== 1'b1; k++) @(posedge clk);
		if (tone_tx !== 1'b1) tmo();
		for (k = 0; k < 3000 && tone_tx === 1'b1; k++) @(posedge clk);
		chk("tone_len_min", 32'(k), 32'(16 * US_CYC));
		chk("oe_aoa_end", pin_oe, 32'h0);
		$display("test tx_plain done");
	endtask : t_tx_plain

	task automatic t_tx_switch();
		int k, n;
		int tm [8];
		logic [7:0] v [8];
		logic [7:0] prev;
		// signal 7 left disconnected
		for (n = 0; n < 8; n++)
			apb(1'b1, OFS_PIN0 + 12'(4 * n), 32'(n) | (n < 7 ? 32'h20 : 32'h0));
		for (n = 0; n < 4; n++) apb(1'b1, OFS_PATTERN, 32'(8'h11 << n));
		apb(1'b1, OFS_OFFSET, 32'h0);
		apb(1'b1, OFS_CTRL, 32'h0300_0203);
		pulse(0);
		repeat (2) @(posedge clk);
		chk("oe_acq", pin_oe, 32'h0000_007F);
		chk("entry0", 32'(pin_out[6:0]), 32'h11);
		pulse(3);
		n = 0;
		prev = {1'b0, pin_out[6:0]};
		for (k = 0; k < 3000; k++) begin
			@(posedge clk);
			if (pin_oe[0] !== 1'b1) break;
			if ({1'b0, pin_out[6:0]} !== prev && n < 8) begin
				tm[n] = k;
				v[n] = {1'b0, pin_out[6:0]};
				n++;
			end
			prev = {1'b0, pin_out[6:0]};
		end
		chk("changes", 32'(n >= 5), 32'h1);
		chk("entry1", 32'(v[0]), 32'h22);
		chk("entry2", 32'(v[1]), 32'h44);
		chk("guard_ref", 32'(tm[1] - tm[0]), 32'(GREF_CYC));
		chk("entry3", 32'(v[2]), 32'h08);
		chk("slot", 32'(tm[2] - tm[1]), 32'(2 * US_CYC));
		chk("wrap", 32'(v[3]), 32'h44);
		chk("tail", 32'(v[n-1]), 32'h11);
		chk("tail_gap", 32'(tm[n-1] - tm[n-2]), 32'(2 * US_CYC));
		chk("released", pin_oe, 32'h0);
		$display("test tx_switch done");
	endtask : t_tx_switch

	task automatic t_rx_iq();
		int k;
		logic [7:0] b;
		b = ram_cnt;
		dly <= 8'h0;
		iq_i <= 12'h800;
		iq_q <= 12'h123;
		apb(1'b1, OFS_INLINE, 32'h0);
		apb(1'b1, OFS_PTR, 32'h0000_1000);
		apb(1'b1, OFS_MAX, 32'h3);
		apb(1'b1, OFS_OFFSET, 32'h0000_0200);
		apb(1'b1, OFS_CTRL, 32'h0303_3200);
		pulse(1);
		repeat (2) @(posedge clk);
		chk("oe_aoa_rx", pin_oe, 32'h0000_007F);
		pulse(3);
		for (k = 0; k < 200 && dma_req !== 1'b1; k++) @(posedge clk);
		chk("first_take", 32'(k >= 100 && k <= 104), 32'h1);
		wait_cnt(b + 8'h1);
		iq_q_ovf <= 1'b1;
		wait_cnt(b + 8'h3);
		repeat (600) @(posedge clk);
		chk("capped", 32'(ram_cnt - b), 32'h3);
		apb(1'b0, OFS_AMOUNT, 32'h0);
		chk("amount", rd, 32'h3);
		for (k = 0; k < 3; k++)
			chk("addr", ram.addr_log[4'(b + k)], 32'h1000 + 32'(4 * k));
		chk("iq_sign", ram.data_log[4'(b)], 32'h0123_F800);
		chk("iq_sat", ram.data_log[4'(b + 2)], 32'h8000_F800);
		iq_q_ovf <= 1'b0;
		repeat (1200) @(posedge clk);
		$display("test rx_iq done");
	endtask : t_rx_iq

	task automatic t_rx_mag();
		logic [7:0] b;
		b = ram_cnt;
		dly <= 8'h5;
		mag_in <= 13'h1ABC;
		phase_in <= 9'h0FF;
		apb(1'b1, OFS_PTR, 32'h0000_2000);
		apb(1'b1, OFS_MAX, 32'h2);
		apb(1'b1, OFS_CTRL, 32'h0303_3209);
		pulse(1);
		repeat (2) @(posedge clk);
		chk("oe_aod_rx", pin_oe, 32'h0);
		pulse(3);
		wait_cnt(b + 8'h1);
		phase_in <= 9'h100;
		wait_cnt(b + 8'h2);
		repeat (400) @(posedge clk);
		chk("capped", 32'(ram_cnt - b), 32'h2);
		chk("addr", ram.addr_log[4'(b + 1)], 32'h0000_2004);
		chk("mag_pos", ram.data_log[4'(b)], 32'h1ABC_00C9);
		chk("mag_neg", ram.data_log[4'(b + 1)], 32'h1ABC_FF37);
		repeat (1200) @(posedge clk);
		$display("test rx_mag done");
	endtask : t_rx_mag

	task automatic t_inline();
		int c, k, f0;
		apb(1'b1, OFS_MAX, 32'h0);
		apb(1'b1, OFS_CTRL, 32'h0003_3200);
		for (c = 0; c < 4; c++) begin
			apb(1'b1, OFS_INLINE, CFG[c]);
			f0 = found_n;
			pulse(1);
			pulse(2);
			for (k = 0; k < 11; k++) begin
				@(posedge clk);
				rx_byte <= PK[c][8*k +: 8];
				rx_byte_valid <= 1'b1;
				@(posedge clk);
				rx_byte_valid <= 1'b0;
			end
			pulse(3);
			repeat (1200) @(posedge clk);
			chk("found_pulses", 32'(found_n - f0), 32'(EXPF[c]));
			apb(1'b0, OFS_STATUS, 32'h0);
			chk("found_flag", 32'(rd[31]), 32'(EXPF[c]));
			if (EXPF[c]) chk("info", 32'(rd[7:0]), 32'h02);
		end
		$display("test inline done");
	endtask : t_inline

	task automatic t_trig();
		int k;
		logic [7:0] b;
		b = ram_cnt;
		dly <= 8'h0;
		apb(1'b1, OFS_INLINE, 32'h0);
		apb(1'b1, OFS_MAX, 32'h1);
		apb(1'b1, OFS_OFFSET, 32'h0000_0100);
		apb(1'b1, OFS_CTRL, 32'h0303_3205);
		pulse(1);
		pulse(2);
		for (k = 0; k < 200 && dma_req !== 1'b1; k++) @(posedge clk);
		chk("addr_trigger", 32'(k >= US_CYC && k <= US_CYC + 4), 32'h1);
		pulse(3);
		repeat (1400) @(posedge clk);
		chk("trig_count", 32'(ram_cnt - b), 32'h1);
		$display("test trigger done");
	endtask : t_trig

	initial begin
		rst <= 1'b1;
		{psel, penable, pwrite, rx_byte_valid, iq_i_ovf, iq_q_ovf} <= 6'h0;
		{paddr, pwdata, ev, rx_byte, dly} <= '0;
		{iq_i, iq_q, mag_in, phase_in} <= '0;
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		t_regs();
		t_tx_plain();
		t_tx_switch();
		t_rx_iq();
		t_rx_mag();
		t_inline();
		t_trig();
		summarize();
	end
endmodule : testbench
`default_nettype wire
